/* src/ipw_pkg.sv */
// Package with register map, field layout and shared types of the interrupt priority block.
package ipw_pkg;
  localparam int          IPW_NUM_SRC      = 17;
  localparam int          IPW_LVL_W        = 3;
  localparam int          IPW_FIELD_LSB    = 5;
  localparam int          IPW_SRC_PER_REG  = 4;
  localparam int          IPW_NUM_PRI_REG  = 5;
  localparam logic [11:0] IPW_OFF_SET_EN   = 12'h000;
  localparam logic [11:0] IPW_OFF_CLR_EN   = 12'h004;
  localparam logic [11:0] IPW_OFF_SET_PEND = 12'h008;
  localparam logic [11:0] IPW_OFF_CLR_PEND = 12'h00C;
  localparam logic [11:0] IPW_OFF_ACTIVE   = 12'h010;
  localparam logic [11:0] IPW_OFF_IRQ_STAT = 12'h014;
  localparam logic [11:0] IPW_OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] IPW_OFF_PRI_BASE = 12'h020;
  localparam logic [11:0] IPW_OFF_PRI_LAST = 12'h030;
  localparam logic [31:0] IPW_WAKE_CAPABLE = 32'h0000040F;
  localparam logic [2:0]  IPW_PRI_RESET    = 3'h0;
  localparam logic [1:0]  IPW_EVT_WAKE     = 2'h0;
  localparam logic [1:0]  IPW_EVT_PEND_DIS = 2'h1;
  localparam logic [1:0]  IPW_EVT_W        = 2'h2;

  typedef enum logic [1:0] {
    IPW_PWR_ACTIVE    = 2'b00,
    IPW_PWR_SLEEP     = 2'b01,
    IPW_PWR_HIBERNATE = 2'b10
  } ipw_pwr_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] position;
    logic [2:0] level;
  } ipw_winner_t;
endpackage : ipw_pkg

/* src/ipw_arbiter.sv */
// Picks the most urgent pending enabled source, ties going to the lowest position.
`timescale 1ns/100ps
module ipw_arbiter
  import ipw_pkg::*;
#(
  parameter int N = 17
) (
  input  wire logic [N-1:0]            req,
  input  wire logic [N*IPW_LVL_W-1:0]  level,
  output ipw_winner_t                  winner
);
  always_comb begin
    winner = '0;
    // Scanning downward with a non-strict compare lets the lower position win a tie.
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!winner.valid || level[i*IPW_LVL_W +: IPW_LVL_W] <= winner.level)) begin
        winner.valid    = 1'b1;
        winner.position = 5'(i);
        winner.level    = level[i*IPW_LVL_W +: IPW_LVL_W];
      end
    end
  end
endmodule : ipw_arbiter

/* src/ipw_ctrl.sv */
// Interrupt enable, pending, priority and wake-up control with an APB register port.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module ipw_ctrl
  import ipw_pkg::*;
#(
  parameter int N = IPW_NUM_SRC
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [N-1:0] irq_src,
  input  wire logic         ext_irq0_pin,
  input  wire logic         ext_irq1_pin,
  input  wire logic         core_ack,
  input  wire logic         core_exc_return,
  input  wire logic         sleep_req,
  input  wire logic         hibernate_req,
  output logic              core_irq_req,
  output logic      [4:0]   core_irq_position,
  output logic      [2:0]   core_irq_level,
  output logic      [1:0]   power_mode,
  output logic              core_wake,
  output logic              irq
);
  // Source map: 0 wake timer, 1 ext0, 2 ext1, 3 watchdog, 4 timer0, 5 ADC, 6 flash, 7 SPI,
  // 8 bus header, 9 bus error, 10 bus wake, 11 HV, 12 osc cal, 13 ECC, 14..16 unused.
  // Sources are in the pclk domain; ext pins alone need synchronising.
  logic [N-1:0]           enable;
  logic [N-1:0]           pending;
  logic [N-1:0]           active;
  logic [N*IPW_LVL_W-1:0] level;
  logic [N-1:0]           src_q;
  logic [2:0]             ext0_sync;
  logic [2:0]             ext1_sync;
  logic                   ext0_level;
  logic                   ext1_level;
  logic [N-1:0]           src_now;
  logic [N-1:0]           src_rise;
  logic [IPW_EVT_W-1:0]   evt_stat;
  logic [IPW_EVT_W-1:0]   evt_mask;
  ipw_pwr_t               pwr_state;
  ipw_winner_t            winner;
  logic                   wr_en;
  logic                   rd_en;
  logic                   addr_ok;
  logic [31:0]            wmask;
  logic [31:0]            wdata_m;
  logic                   take;
  logic                   wake_evt;
  logic                   pend_dis_evt;
  logic [N-1:0]           set_pend_wr;
  logic [N-1:0]           clr_pend_wr;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata_m = pwdata & wmask;

  always_comb begin
    addr_ok = 1'b0;
    if (paddr == IPW_OFF_SET_EN || paddr == IPW_OFF_CLR_EN) begin
      addr_ok = 1'b1;
    end else if (paddr == IPW_OFF_SET_PEND || paddr == IPW_OFF_CLR_PEND) begin
      addr_ok = 1'b1;
    end else if (paddr == IPW_OFF_ACTIVE || paddr == IPW_OFF_IRQ_STAT) begin
      addr_ok = 1'b1;
    end else if (paddr == IPW_OFF_IRQ_MASK) begin
      addr_ok = 1'b1;
    end else if (paddr >= IPW_OFF_PRI_BASE && paddr <= IPW_OFF_PRI_LAST && paddr[1:0] == 2'h0) begin
      addr_ok = 1'b1;
    end
  end
  assign pslverr = psel && penable && !addr_ok;

  // Three-stage synchronisers; a pin change counts once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext0_sync  <= 3'h0;
      ext1_sync  <= 3'h0;
      ext0_level <= 1'b0;
      ext1_level <= 1'b0;
    end else begin
      ext0_sync <= {ext0_sync[1:0], ext_irq0_pin};
      ext1_sync <= {ext1_sync[1:0], ext_irq1_pin};
      if (ext0_sync[2] == ext0_sync[1]) begin
        ext0_level <= ext0_sync[2];
      end
      if (ext1_sync[2] == ext1_sync[1]) begin
        ext1_level <= ext1_sync[2];
      end
    end
  end

  always_comb begin
    src_now    = irq_src;
    src_now[1] = irq_src[1] | ext0_level;
    src_now[2] = irq_src[2] | ext1_level;
  end
  assign src_rise = src_now & ~src_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= '0;
    end else begin
      src_q <= src_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= '0;
    end else if (wr_en && paddr == IPW_OFF_SET_EN) begin
      enable <= enable | wdata_m[N-1:0];
    end else if (wr_en && paddr == IPW_OFF_CLR_EN) begin
      enable <= enable & ~wdata_m[N-1:0];
    end
  end

  assign set_pend_wr = (wr_en && paddr == IPW_OFF_SET_PEND) ? wdata_m[N-1:0] : '0;
  assign clr_pend_wr = (wr_en && paddr == IPW_OFF_CLR_PEND) ? wdata_m[N-1:0] : '0;
  assign take        = core_ack && winner.valid;

  // Pending latches regardless of enable; a new edge beats a simultaneous clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (src_rise[i] || set_pend_wr[i]) begin
          pending[i] <= 1'b1;
        end else if (clr_pend_wr[i] || (take && winner.position == 5'(i))) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  // Active stays set through disable until the handler returns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (take && winner.position == 5'(i)) begin
          active[i] <= 1'b1;
        end else if (core_exc_return) begin
          active[i] <= 1'b0;
        end
      end
    end
  end

  // Fields sit at byte bits 7:5; bits 4:0 of each byte are never stored.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_pri
      localparam int RIDX = g / IPW_SRC_PER_REG;
      localparam int BLSB = (g % IPW_SRC_PER_REG) * 8 + IPW_FIELD_LSB;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level[g*IPW_LVL_W +: IPW_LVL_W] <= IPW_PRI_RESET;
        end else if (wr_en && paddr == IPW_OFF_PRI_BASE + 12'(RIDX * 4) &&
                     pstrb[g % IPW_SRC_PER_REG]) begin
          level[g*IPW_LVL_W +: IPW_LVL_W] <= pwdata[BLSB +: IPW_LVL_W];
        end
      end
    end
  endgenerate

  ipw_arbiter #(
    .N (N)
  ) u_arb (
    .req    (pending & enable & ~active),
    .level  (level),
    .winner (winner)
  );

  // Level 0 maps to the fourth system urgency; reset, NMI and hard fault sit in the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_req      <= 1'b0;
      core_irq_position <= 5'h0;
      core_irq_level    <= 3'h0;
    end else begin
      core_irq_req      <= winner.valid && !take;
      core_irq_position <= winner.position;
      core_irq_level    <= winner.level;
    end
  end

  assign wake_evt     = |(src_rise & IPW_WAKE_CAPABLE[N-1:0]) && pwr_state != IPW_PWR_ACTIVE;
  assign pend_dis_evt = |(src_rise & ~enable);

  // Sleep wakes on any enabled source; hibernate only on wake-capable ones.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_state <= IPW_PWR_ACTIVE;
      core_wake <= 1'b0;
    end else begin
      core_wake <= 1'b0;
      case (pwr_state)
        IPW_PWR_ACTIVE: begin
          if (hibernate_req) begin
            pwr_state <= IPW_PWR_HIBERNATE;
          end else if (sleep_req) begin
            pwr_state <= IPW_PWR_SLEEP;
          end
        end
        IPW_PWR_SLEEP: begin
          if (|(src_rise & enable) || wake_evt) begin
            pwr_state <= IPW_PWR_ACTIVE;
            core_wake <= 1'b1;
          end
        end
        IPW_PWR_HIBERNATE: begin
          if (wake_evt) begin
            pwr_state <= IPW_PWR_ACTIVE;
            core_wake <= 1'b1;
          end
        end
        default: begin
          pwr_state <= IPW_PWR_ACTIVE;
        end
      endcase
    end
  end
  assign power_mode = pwr_state;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat <= '0;
    end else begin
      for (int i = 0; i < IPW_EVT_W; i++) begin
        if ((i == IPW_EVT_WAKE && wake_evt) || (i == IPW_EVT_PEND_DIS && pend_dis_evt)) begin
          evt_stat[i] <= 1'b1;
        end else if (wr_en && paddr == IPW_OFF_IRQ_STAT && wdata_m[i]) begin
          evt_stat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask <= '0;
    end else if (wr_en && paddr == IPW_OFF_IRQ_MASK) begin
      evt_mask <= wdata_m[IPW_EVT_W-1:0];
    end
  end
  assign irq = |(evt_stat & evt_mask);

  // Read data is registered in the setup cycle so it is valid for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en && !penable) begin
      prdata <= 32'h0;
      if (paddr == IPW_OFF_SET_EN || paddr == IPW_OFF_CLR_EN) begin
        prdata[N-1:0] <= enable;
      end else if (paddr == IPW_OFF_SET_PEND || paddr == IPW_OFF_CLR_PEND) begin
        prdata[N-1:0] <= pending;
      end else if (paddr == IPW_OFF_ACTIVE) begin
        prdata[N-1:0] <= active;
      end else if (paddr == IPW_OFF_IRQ_STAT) begin
        prdata[IPW_EVT_W-1:0] <= evt_stat;
      end else if (paddr == IPW_OFF_IRQ_MASK) begin
        prdata[IPW_EVT_W-1:0] <= evt_mask;
      end else if (paddr >= IPW_OFF_PRI_BASE && paddr <= IPW_OFF_PRI_LAST) begin
        for (int k = 0; k < IPW_SRC_PER_REG; k++) begin
          if (int'(paddr[5:2] - 4'h8) * IPW_SRC_PER_REG + k < N) begin
            prdata[k*8 + IPW_FIELD_LSB +: IPW_LVL_W] <=
              level[(int'(paddr[5:2] - 4'h8) * IPW_SRC_PER_REG + k) * IPW_LVL_W +: IPW_LVL_W];
          end
        end
      end
    end
  end
endmodule : ipw_ctrl

/* testbench/ipw_ctrl_props.sv */
// Concurrent checks on the register port, core handshake and power outputs of ipw_ctrl.
`timescale 1ns/100ps
module ipw_ctrl_props
  import ipw_pkg::*;
#(
  parameter int N = IPW_NUM_SRC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_ack,
  input wire logic        core_irq_req,
  input wire logic [4:0]  core_irq_position,
  input wire logic [1:0]  power_mode,
  input wire logic        core_wake,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mapped;
  logic pri;
  assign acc = psel && penable;
  assign pri = paddr >= 12'h020 && paddr <= 12'h030;
  assign mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h018 || pri);
  sequence s_take;
    core_ack && core_irq_req;
  endsequence
  sequence s_hib_exit;
    power_mode == IPW_PWR_ACTIVE && $past(power_mode) == IPW_PWR_HIBERNATE;
  endsequence
  AST_PREADY: assert property (acc |-> pready) else $error("pready low in access");
  AST_SLVERR: assert property (pslverr == (acc && !mapped)) else $error("pslverr wrong");
  AST_ERR_READ_ZERO: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RSVD_ZERO: assert property (acc && !pwrite && mapped && pri |->
    (prdata & (paddr == 12'h030 ? 32'hFFFFFF1F : 32'h1F1F1F1F)) == 32'h0)
    else $error("reserved priority bits set");
  AST_TAKE_MOVES_ON: assert property (s_take |=> ##1
    (!core_irq_req || core_irq_position != $past(core_irq_position, 2)))
    else $error("taken source offered again");
  AST_HIB_EXIT_WAKE: assert property (s_hib_exit |->
    $past(core_wake) or ##[0:1] core_wake)
    else $error("left hibernate without wake");
  AST_WAKE_TO_ACTIVE: assert property (core_wake |-> ##[0:1] power_mode == IPW_PWR_ACTIVE)
    else $error("wake without active mode");
  AST_WAKE_PULSE: assert property (core_wake |=> !core_wake) else $error("wake longer than one");
  AST_RESET_QUIET: assert property (disable iff (1'b0) !presetn |->
    !core_irq_req && !irq && !core_wake && power_mode == IPW_PWR_ACTIVE)
    else $error("outputs busy in reset");
endmodule : ipw_ctrl_props

bind ipw_ctrl ipw_ctrl_props #(.N(N)) u_ipw_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_ack(core_ack), .core_irq_req(core_irq_req),
  .core_irq_position(core_irq_position), .power_mode(power_mode), .core_wake(core_wake),
  .irq(irq));

/* testbench/ipw_core_model.sv */
// Behavioural processor core that takes the offered interrupt and later returns from it.
`timescale 1ns/100ps
module ipw_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [3:0] lat,
  input  wire logic       req,
  input  wire logic [4:0] pos,
  output logic            ack,
  output logic            ret,
  output logic      [4:0] taken_pos,
  output logic      [7:0] taken_cnt
);
  logic [3:0] cnt;
  logic       busy;
  // Waiting lat cycles before taking and before returning covers prompt and slow cores alike.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ack, ret, busy, cnt, taken_pos, taken_cnt} <= '0;
    end else begin
      ack <= 1'b0;
      ret <= 1'b0;
      cnt <= cnt + 4'h1;
      if (busy && cnt >= lat) begin
        ret  <= 1'b1;
        busy <= 1'b0;
        cnt  <= 4'h0;
      end else if (!busy && !(go && req && !ret)) begin
        cnt <= 4'h0;
      end else if (!busy && cnt >= lat) begin
        ack       <= 1'b1;
        taken_pos <= pos;
        taken_cnt <= taken_cnt + 8'h01;
        busy      <= 1'b1;
        cnt       <= 4'h0;
      end
    end
  end
endmodule : ipw_core_model

/* testbench/irq_priority_wake_ctrl_tb.sv */
// Directed self-checking bench for ipw_ctrl with a core model on the far side.
`timescale 1ns/100ps
module irq_priority_wake_ctrl_tb
  import ipw_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, ext_irq0_pin, sleep_req, hib, go;
  logic        ext_irq1_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, lat;
  logic [16:0] irq_src;
  logic        pready, pslverr, core_ack, core_ret, core_irq_req, core_wake, irq;
  logic [4:0]  core_irq_position, taken_pos;
  logic [2:0]  core_irq_level;
  logic [1:0]  power_mode;
  logic [7:0]  taken_cnt;
  int          err_total, samples_checked;

  ipw_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_src(irq_src), .ext_irq0_pin(ext_irq0_pin),
    .ext_irq1_pin(ext_irq1_pin), .core_ack(core_ack), .core_exc_return(core_ret),
    .sleep_req(sleep_req), .hibernate_req(hib), .core_irq_req(core_irq_req),
    .core_irq_position(core_irq_position), .core_irq_level(core_irq_level),
    .power_mode(power_mode), .core_wake(core_wake), .irq(irq));
  ipw_core_model core (.pclk(pclk), .presetn(presetn), .go(go), .lat(lat),
    .req(core_irq_req), .pos(core_irq_position), .ack(core_ack), .ret(core_ret),
    .taken_pos(taken_pos), .taken_cnt(taken_cnt));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hF};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) err_total++;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask : rd

  task automatic take(input logic [7:0] n, input logic [4:0] exp_pos);
    int k;
    k = 0;
    while (taken_cnt !== n && k < 200) begin
      @(posedge pclk);
      k++;
    end
    chk({24'h0, taken_cnt}, {24'h0, n});
    chk({27'h0, taken_pos}, {27'h0, exp_pos});
  endtask : take

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial begin
    {presetn, psel, penable, pwrite, ext_irq0_pin, ext_irq1_pin, sleep_req, hib, go} = '0;
    {paddr, pwdata, pstrb, irq_src} = '0;
    lat = 4'h3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rd(12'h020 + 12'(4 * i), 32'h0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(12'h020 + 12'(4 * i), 32'hFFFFFFFF);
      rd(12'h020 + 12'(4 * i),
         i == 4 ? 32'h000000E0 : 32'hE0E0E0E0, 1'b0);
    end
    rd(12'h01C, 32'h0, 1'b1);
    wr(IPW_OFF_SET_EN, 32'h0001FFFF);
    wr(IPW_OFF_CLR_EN, 32'h00000010);
    wr(IPW_OFF_SET_EN, 32'h0);
    wr(IPW_OFF_CLR_EN, 32'h0);
    rd(IPW_OFF_SET_EN, 32'h0001FFEF, 1'b0);
    // Source 4 is disabled: it must latch and flag, but never be offered to the core.
    wr(IPW_OFF_IRQ_MASK, 32'h2);
    irq_src[4] <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(IPW_OFF_SET_PEND, 32'h00000010, 1'b0);
    chk({31'h0, core_irq_req}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(IPW_OFF_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(IPW_OFF_IRQ_MASK, 32'h2);
    wr(IPW_OFF_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(IPW_OFF_CLR_PEND, 32'h10);
    rd(IPW_OFF_SET_PEND, 32'h0, 1'b0);
    wr(12'h024, 32'h20E020E0);
    irq_src <= 17'h000A0;
    repeat (4) @(posedge pclk);
    chk({24'h0, core_irq_position, core_irq_level}, {24'h0, 5'h05, 3'h1});
    go <= 1'b1;
    take(8'h01, 5'h05);
    take(8'h02, 5'h07);
    {go, lat, irq_src} <= '0;
    wr(12'h024, 32'h00E020E0);
    irq_src <= 17'h000A0;
    repeat (4) @(posedge pclk);
    go <= 1'b1;
    take(8'h03, 5'h07);
    take(8'h04, 5'h05);
    {go, irq_src} <= '0;
    // Source 3 stands for a watchdog that software has already armed to reset.
    for (int p = 0; p < 17; p++) if (p != 4) begin
      hib <= 1'b1;
      @(posedge pclk);
      hib <= 1'b0;
      repeat (2) @(posedge pclk);
      irq_src[p] <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({30'h0, power_mode}, (17'h0040F >> p) & 1 ? 32'h0 : 32'h2);
      irq_src[p] <= 1'b0;
    end
    ext_irq0_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({30'h0, power_mode}, 32'h0);
    // The second pin must also pull the core out of hibernate through its synchroniser.
    hib          <= 1'b1;
    ext_irq1_pin <= 1'b1;
    @(posedge pclk);
    hib <= 1'b0;
    @(posedge pclk);
    chk({30'h0, power_mode}, 32'h2);
    repeat (8) @(posedge pclk);
    chk({30'h0, power_mode}, 32'h0);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge pclk);
    irq_src[6] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({30'h0, power_mode}, 32'h0);
    rd(IPW_OFF_IRQ_STAT, 32'h00000001, 1'b0);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    conclude();
  end
endmodule : irq_priority_wake_ctrl_tb
